/* File: rtl/dsro_pkg.sv */
// Shared constants, types and helpers for the dual converter serial readout.
// Assumes one system clock of CLK_PERIOD_NS; both ends import this package.
package dsro_pkg;

    // ========================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int TRIG_HIGH_MIN_NS = 15;
    // Least time, rounded up, never below one cycle
    localparam int TRIG_HIGH_CYC = (TRIG_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_PERIOD_MIN_NS = 125;
    localparam int SCLK_PERIOD_MAX_NS = 5000;
    // System cycles per converter clock half period (covers pin round trip)
    localparam int SCLK_HALF_CYC = 8;

    // ========================================================
    // Conversion and frame layout
    localparam int RESULT_W = 12;
    localparam int FRAME_W = 16;
    localparam int CONV_CYCLES = 16;
    localparam int RD_LAT_EDGES = 3;
    localparam int FRAME_PAIR_BIT = 15;
    localparam int FRAME_CHAN_BIT = 14;
    localparam int FRAME_MSB_BIT = 13;
    localparam logic CHAN_A = 1'b0;
    localparam logic CHAN_B = 1'b1;
    localparam logic [1:0] FRAME_TAIL = 2'b00;
    localparam int FIFO_DEPTH = 32;

    typedef logic [RESULT_W-1:0] dsro_result_t;
    typedef logic [FRAME_W-1:0] dsro_frame_t;

    // Build one output frame: pair flag, converter flag, result, two zeros
    function automatic dsro_frame_t dsro_make_frame(input logic pair, input logic chan,
                                                    input dsro_result_t res);
        dsro_make_frame = {pair, chan, res, FRAME_TAIL};
    endfunction : dsro_make_frame

endpackage : dsro_pkg

/* File: rtl/dsro_link_if.sv */
// Pin bundle between the converter end and the host controller end.
// Assumes both ends run on the same system clock; sclk is a pin driven by the host.
`timescale 1ns/1ns
interface dsro_link_if;
    logic conv_trig;
    logic read_strobe;
    logic cs_n;
    logic chcount_sel;
    logic outport_sel;
    logic pair_select;
    logic sclk;
    logic busy;
    logic sdo_a_o;
    logic sdo_a_oe;
    logic sdo_b_o;
    logic sdo_b_oe;

    // ========================================================
    // Converter end
    modport dev (
        input conv_trig, read_strobe, cs_n, chcount_sel, outport_sel, pair_select, sclk,
        output busy, sdo_a_o, sdo_a_oe, sdo_b_o, sdo_b_oe
    );

    // ========================================================
    // Host end
    modport host (
        output conv_trig, read_strobe, cs_n, chcount_sel, outport_sel, pair_select, sclk,
        input busy, sdo_a_o, sdo_a_oe, sdo_b_o, sdo_b_oe
    );
endinterface : dsro_link_if

/* File: rtl/dsro_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and asynchronous active-high reset.
`timescale 1ns/1ns
module dsro_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
    logic full, empty, push, pop;

    // ========================================================
    // Status and pointer update
    always_comb begin
        empty = (wr_ptr_r == rd_ptr_r);
        full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
        in_ready = !full;
        out_valid = !empty;
        push = in_valid && !full;
        pop = out_ready && !empty;
        wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
        rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
        out_data = mem[rd_ptr_r[AW-1:0]];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
        end
    end

    // Storage array, written on accepted push
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end
endmodule : dsro_fifo

/* File: rtl/dsro_device.sv */
// Converter end: conversion control, busy, pair select and serial frame readout.
// Assumes all link pins come from the host and are synchronised here to CLOCK.
//
// Behaviour
// - channel count pin: fixed pair or auto alternate
// - output port pin: two outputs or one
// - host holds trigger high at least 15ns
// - host raises trigger with a falling clock edge, clear of rising edges
// - conversion lasts sixteen external clock cycles
// - trigger puts sample-and-hold into hold immediately
// - busy high for the whole conversion
// - pair select captured at first falling edge
// - host ties trigger and read strobe together
// - outputs driven only while chip select low
// - one output bit per rising clock edge
// - frame: pair, converter, result, two zeros
// - results in 12-bit two's complement
// - second output tristates in single-output mode
// - single-output readout lasts thirty-two cycles
// - triggers inside single-output readout are ignored
// - data valid after third rising edge after strobe
`timescale 1ns/1ns
module dsro_device
    import dsro_pkg::*;
(
    dsro_link_if.dev LINK,
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire dsro_pkg::dsro_result_t RESULT_A0,
    input wire dsro_pkg::dsro_result_t RESULT_A1,
    input wire dsro_pkg::dsro_result_t RESULT_B0,
    input wire dsro_pkg::dsro_result_t RESULT_B1,
    output logic HOLD,
    output logic CUR_PAIR
);
    import dsro_pkg::*;

    typedef enum logic [2:0] {
        C_IDLE = 3'b001,
        C_WAIT = 3'b010,
        C_CONV = 3'b100
    } dsro_conv_t;

    // ========================================================
    // Pin synchronisers
    localparam int NPIN = 7;
    logic [NPIN-1:0] pins, sync1_r, sync2_r, prev_r;
    logic s_sclk, s_trig, s_rd, s_cs_n, s_chc, s_outp, s_pair;
    logic sclk_rise, sclk_fall, trig_rise, rd_rise;

    assign pins = {LINK.sclk, LINK.conv_trig, LINK.read_strobe, LINK.cs_n,
                   LINK.chcount_sel, LINK.outport_sel, LINK.pair_select};

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sync1_r <= 7'h08; // Both stages idle deselected
            sync2_r <= 7'h08; // Chip select idles high
            prev_r <= 7'h08;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // Edge pulses from the second stage only
    always_comb begin
        {s_sclk, s_trig, s_rd, s_cs_n, s_chc, s_outp, s_pair} = sync2_r;
        sclk_rise = s_sclk && !prev_r[6];
        sclk_fall = !s_sclk && prev_r[6];
        trig_rise = s_trig && !prev_r[5];
        rd_rise = s_rd && !prev_r[4];
    end

    // ========================================================
    // Conversion control
    dsro_conv_t state_r, state_nxt;
    logic [4:0] conv_cnt_r, conv_cnt_nxt;
    logic hold_r, hold_nxt, busy_r, busy_nxt;
    logic cur_pair_r, cur_pair_nxt, next_pair_r, next_pair_nxt;
    logic pair_taken_r, pair_taken_nxt, b_tri_r, b_tri_nxt;
    dsro_result_t res_a_r, res_a_nxt, res_b_r, res_b_nxt;
    logic readout_busy;

    always_comb begin
        state_nxt = state_r;
        conv_cnt_nxt = conv_cnt_r;
        hold_nxt = hold_r;
        busy_nxt = busy_r;
        cur_pair_nxt = cur_pair_r;
        next_pair_nxt = next_pair_r;
        pair_taken_nxt = pair_taken_r;
        b_tri_nxt = b_tri_r;
        res_a_nxt = res_a_r;
        res_b_nxt = res_b_r;
        unique case (state_r)
            C_IDLE: begin
                if (trig_rise && !(s_outp && readout_busy)) begin
                    hold_nxt = 1'b1;
                    busy_nxt = 1'b1;
                    cur_pair_nxt = next_pair_r;
                    res_a_nxt = next_pair_r ? RESULT_A1 : RESULT_A0;
                    res_b_nxt = next_pair_r ? RESULT_B1 : RESULT_B0;
                    state_nxt = C_WAIT;
                end
            end
            C_WAIT: begin
                if (sclk_rise) begin
                    conv_cnt_nxt = 5'h01;
                    pair_taken_nxt = 1'b0;
                    state_nxt = C_CONV;
                end
            end
            C_CONV: begin
                if (sclk_fall && !pair_taken_r) begin
                    pair_taken_nxt = 1'b1;
                    next_pair_nxt = s_chc ? !cur_pair_r : s_pair;
                end
                if (sclk_rise) begin
                    if (conv_cnt_r == 5'(CONV_CYCLES)) begin
                        busy_nxt = 1'b0;
                        hold_nxt = 1'b0;
                        b_tri_nxt = s_outp;
                        state_nxt = C_IDLE;
                    end else begin
                        conv_cnt_nxt = conv_cnt_r + 5'h01;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_r <= C_IDLE;
            conv_cnt_r <= '0;
            hold_r <= 1'b0;
            busy_r <= 1'b0;
            cur_pair_r <= 1'b0;
            next_pair_r <= 1'b0;
            pair_taken_r <= 1'b0;
            b_tri_r <= 1'b0;
            res_a_r <= '0;
            res_b_r <= '0;
        end else begin
            state_r <= state_nxt;
            conv_cnt_r <= conv_cnt_nxt;
            hold_r <= hold_nxt;
            busy_r <= busy_nxt;
            cur_pair_r <= cur_pair_nxt;
            next_pair_r <= next_pair_nxt;
            pair_taken_r <= pair_taken_nxt;
            b_tri_r <= b_tri_nxt;
            res_a_r <= res_a_nxt;
            res_b_r <= res_b_nxt;
        end
    end

    // ========================================================
    // Serial readout
    logic rd_arm_r, rd_arm_nxt;
    logic [1:0] rd_cnt_r, rd_cnt_nxt;
    logic [5:0] bits_left_r, bits_left_nxt;
    logic [2*FRAME_W-1:0] sh_a_r, sh_a_nxt;
    dsro_frame_t sh_b_r, sh_b_nxt, frame_a, frame_b;

    always_comb begin
        frame_a = dsro_make_frame(cur_pair_r, CHAN_A, res_a_r);
        frame_b = dsro_make_frame(cur_pair_r, CHAN_B, res_b_r);
        readout_busy = rd_arm_r || (bits_left_r != 6'h00);
        rd_arm_nxt = rd_arm_r;
        rd_cnt_nxt = rd_cnt_r;
        bits_left_nxt = bits_left_r;
        sh_a_nxt = sh_a_r;
        sh_b_nxt = sh_b_r;
        if (rd_rise && !readout_busy) begin
            rd_arm_nxt = 1'b1;
            rd_cnt_nxt = 2'h0;
        end else if (sclk_rise && rd_arm_r) begin
            if (rd_cnt_r == 2'(RD_LAT_EDGES - 1)) begin
                rd_arm_nxt = 1'b0;
                sh_a_nxt = s_outp ? {frame_a, frame_b} : {frame_a, 16'h0000};
                sh_b_nxt = frame_b;
                bits_left_nxt = s_outp ? 6'(2 * FRAME_W) : 6'(FRAME_W);
            end else begin
                rd_cnt_nxt = rd_cnt_r + 2'h1;
            end
        end else if (sclk_rise && bits_left_r != 6'h00) begin
            bits_left_nxt = bits_left_r - 6'h01;
            sh_a_nxt = {sh_a_r[2*FRAME_W-2:0], 1'b0};
            sh_b_nxt = {sh_b_r[FRAME_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rd_arm_r <= 1'b0;
            rd_cnt_r <= '0;
            bits_left_r <= '0;
            sh_a_r <= '0;
            sh_b_r <= '0;
        end else begin
            rd_arm_r <= rd_arm_nxt;
            rd_cnt_r <= rd_cnt_nxt;
            bits_left_r <= bits_left_nxt;
            sh_a_r <= sh_a_nxt;
            sh_b_r <= sh_b_nxt;
        end
    end

    // ========================================================
    // Pin outputs
    // drive only under select
    assign LINK.sdo_a_oe = !s_cs_n;
    assign LINK.sdo_b_oe = !s_cs_n && !b_tri_r;
    assign LINK.sdo_a_o = sh_a_r[2*FRAME_W-1];
    assign LINK.sdo_b_o = sh_b_r[FRAME_W-1];
    assign LINK.busy = busy_r;
    assign CUR_PAIR = cur_pair_r;
    assign HOLD = hold_r || (LINK.conv_trig && state_r == C_IDLE && !(s_outp && readout_busy));
endmodule : dsro_device

/* File: rtl/dsro_host.sv */
// Host end: makes the converter clock, triggers conversions, captures frames.
// Assumes the converter end is joined through dsro_link_if on the same CLOCK.
`timescale 1ns/1ns
module dsro_host
    import dsro_pkg::*;
#(
    parameter int HALF_CYC = dsro_pkg::SCLK_HALF_CYC,
    parameter int DEPTH = dsro_pkg::FIFO_DEPTH
) (
    dsro_link_if.host LINK,
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic RUN,
    input wire logic CHCOUNT_SEL,
    input wire logic OUTPORT_SEL,
    input wire logic PAIR_SEL,
    output logic [dsro_pkg::FRAME_W-1:0] OUT_DATA,
    output logic OUT_VALID,
    input wire logic OUT_READY
);
    import dsro_pkg::*;

    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_TRIG = 4'b0010,
        H_CAP = 4'b0100,
        H_PUSH = 4'b1000
    } dsro_host_t;

    // ========================================================
    // Converter clock divider
    logic [7:0] div_r, div_nxt;
    logic sclk_r, sclk_nxt, rise_en, fall_en, flip;

    always_comb begin
        flip = (div_r == 8'(HALF_CYC - 1));
        div_nxt = flip ? 8'h00 : div_r + 8'h01;
        sclk_nxt = flip ? !sclk_r : sclk_r;
        rise_en = flip && !sclk_r;
        fall_en = flip && sclk_r;
    end

    // ========================================================
    // Serial data synchronisers
    logic [1:0] sdo1_r, sdo2_r;

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            div_r <= '0;
            sclk_r <= 1'b0;
            sdo1_r <= '0;
            sdo2_r <= '0;
        end else begin
            div_r <= div_nxt;
            sclk_r <= sclk_nxt;
            sdo1_r <= {LINK.sdo_a_o, LINK.sdo_b_o};
            sdo2_r <= sdo1_r;
        end
    end

    // ========================================================
    // Trigger, capture and push sequence
    dsro_host_t state_r, state_nxt;
    logic trig_r, trig_nxt, cs_n_r, cs_n_nxt, single_r, single_nxt, word_r, word_nxt;
    logic [1:0] rise_cnt_r, rise_cnt_nxt;
    logic [5:0] bits_r, bits_nxt;
    logic [2*FRAME_W-1:0] cap_a_r, cap_a_nxt;
    dsro_frame_t cap_b_r, cap_b_nxt, push_data;
    logic push_valid, push_ready;

    always_comb begin
        state_nxt = state_r;
        trig_nxt = trig_r;
        cs_n_nxt = !RUN && state_r == H_IDLE;
        single_nxt = single_r;
        word_nxt = word_r;
        rise_cnt_nxt = rise_cnt_r;
        bits_nxt = bits_r;
        cap_a_nxt = cap_a_r;
        cap_b_nxt = cap_b_r;
        push_valid = 1'b0;
        push_data = word_r ? (single_r ? cap_a_r[FRAME_W-1:0] : cap_b_r)
                           : (single_r ? cap_a_r[2*FRAME_W-1:FRAME_W] : cap_a_r[FRAME_W-1:0]);
        unique case (state_r)
            H_IDLE: begin
                if (RUN && fall_en) begin
                    trig_nxt = 1'b1;
                    single_nxt = OUTPORT_SEL;
                    rise_cnt_nxt = 2'h0;
                    state_nxt = H_TRIG;
                end
            end
            H_TRIG: begin
                if (fall_en) begin
                    trig_nxt = 1'b0;
                end
                if (rise_en) begin
                    if (rise_cnt_r == 2'(RD_LAT_EDGES - 1)) begin
                        bits_nxt = single_r ? 6'(2 * FRAME_W) : 6'(FRAME_W);
                        state_nxt = H_CAP;
                    end else begin
                        rise_cnt_nxt = rise_cnt_r + 2'h1;
                    end
                end
            end
            H_CAP: begin
                if (fall_en) begin
                    cap_a_nxt = {cap_a_r[2*FRAME_W-2:0], sdo2_r[1]};
                    cap_b_nxt = {cap_b_r[FRAME_W-2:0], sdo2_r[0]};
                    bits_nxt = bits_r - 6'h01;
                    if (bits_r == 6'h01) begin
                        word_nxt = 1'b0;
                        state_nxt = H_PUSH;
                    end
                end
            end
            H_PUSH: begin
                push_valid = 1'b1;
                if (push_ready) begin
                    word_nxt = 1'b1;
                    if (word_r) begin
                        state_nxt = H_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_r <= H_IDLE;
            trig_r <= 1'b0;
            cs_n_r <= 1'b1;
            single_r <= 1'b0;
            word_r <= 1'b0;
            rise_cnt_r <= '0;
            bits_r <= '0;
            cap_a_r <= '0;
            cap_b_r <= '0;
        end else begin
            state_r <= state_nxt;
            trig_r <= trig_nxt;
            cs_n_r <= cs_n_nxt;
            single_r <= single_nxt;
            word_r <= word_nxt;
            rise_cnt_r <= rise_cnt_nxt;
            bits_r <= bits_nxt;
            cap_a_r <= cap_a_nxt;
            cap_b_r <= cap_b_nxt;
        end
    end

    // ========================================================
    // Frame buffer toward the user
    dsro_fifo #(.WIDTH(FRAME_W), .DEPTH(DEPTH)) dsro_fifo_inst (
        .clk(CLOCK),
        .rst(SYS_RST),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_data),
        .out_valid(OUT_VALID),
        .out_ready(OUT_READY),
        .out_data(OUT_DATA)
    );

    // ========================================================
    // Pin drive
    assign LINK.sclk = sclk_r;
    assign LINK.conv_trig = trig_r;
    assign LINK.read_strobe = trig_r;
    assign LINK.cs_n = cs_n_r;
    assign LINK.chcount_sel = CHCOUNT_SEL;
    assign LINK.outport_sel = OUTPORT_SEL;
    assign LINK.pair_select = PAIR_SEL;
endmodule : dsro_host

/* File: tb/dsro_link_checker.sv */
// Checker of the link pins between converter end and host end.
// Assumes the pins of one dsro_link_if and the shared system clock.
`timescale 1ns/1ns
module dsro_link_checker
    import dsro_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic conv_trig,
    input wire logic read_strobe,
    input wire logic cs_n,
    input wire logic chcount_sel,
    input wire logic outport_sel,
    input wire logic sclk,
    input wire logic busy,
    input wire logic sdo_a_o,
    input wire logic sdo_a_oe,
    input wire logic sdo_b_oe
);
    // ========================================================
    // Helper: clock rises seen while busy
    localparam int BUSY_RISES = CONV_CYCLES + 1;
    logic sclk_d_r;
    logic [5:0] rise_cnt_r;
    logic [5:0] rise_cnt_nxt;
    // Count rises, clear when idle
    always_comb begin
        rise_cnt_nxt = busy ? rise_cnt_r + {5'h00, sclk & ~sclk_d_r} : 6'h00;
    end
    // Register helper state
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sclk_d_r <= 1'b0;
            rise_cnt_r <= 6'h00;
        end else begin
            sclk_d_r <= sclk;
            rise_cnt_r <= rise_cnt_nxt;
        end
    end
    // ========================================================
    // Link properties
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SYS_RST);
    AST_OE_OFF: assert property (cs_n [*6] |-> !sdo_a_oe && !sdo_b_oe)
        else $error("serial output driven while deselected");
    AST_TRIG_WIDTH: assert property ($rose(conv_trig) |-> conv_trig [*8])
        else $error("trigger pulse too short");
    AST_TRIG_EDGE: assert property ($rose(conv_trig) |-> !$rose(sclk))
        else $error("trigger raised with clock rise");
    AST_RD_TIED: assert property (read_strobe == conv_trig)
        else $error("read strobe differs from trigger");
    AST_BUSY_RISE: assert property ($rose(conv_trig) |-> !busy ##3 busy)
        else $error("busy not raised after trigger");
    AST_BUSY_LEN: assert property ($fell(busy) |-> rise_cnt_r == 6'(BUSY_RISES))
        else $error("busy length wrong");
    AST_BIT_STEP: assert property (sdo_a_oe && $past(sdo_a_oe) && $changed(sdo_a_o)
        |-> $past(sclk, 3) && !$past(sclk, 4))
        else $error("serial bit changed off its clock step");
    AST_B_TRI: assert property ($fell(busy) && outport_sel |-> ##[0:3] !sdo_b_oe)
        else $error("second output still driven");
    // Main scenarios
    cover property ($fell(busy) && outport_sel);
    cover property ($fell(busy) && !outport_sel);
    cover property ($fell(busy) && chcount_sel);
endmodule : dsro_link_checker

/* File: tb/dsro_tb.sv */
// Bench joining converter end and host end over the link; checks frames.
// Assumes the design files and the link checker are compiled first.
`timescale 1ns/1ns
module dsro_tb;
    import dsro_pkg::*;
    // ========================================================
    // Stimulus and observed signals
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic run = 1'b0;
    logic chcount = 1'b0;
    logic outport = 1'b0;
    logic pair_sel = 1'b0;
    logic out_ready = 1'b1;
    dsro_result_t res_a0 = 12'hFFF;
    dsro_result_t res_b0 = 12'h000;
    dsro_result_t res_a1 = 12'h7FF;
    dsro_result_t res_b1 = 12'h800;
    dsro_frame_t out_data;
    logic out_valid;
    logic hold;
    logic cur_pair;
    dsro_frame_t words[$];
    dsro_frame_t sh = 16'h0000;
    dsro_frame_t want_a;
    dsro_frame_t want_b;
    logic seen_a;
    logic seen_b;
    logic b_drv;
    int miscompares = 0;
    int check_count = 0;
    wire sdo_a;
    dsro_link_if link ();
    // Wire level from the output enable
    assign sdo_a = link.sdo_a_oe ? link.sdo_a_o : 1'bz;
    always #50 clock = ~clock;
    // ========================================================
    // Both ends and the checker
    dsro_device dsro_device_inst (.LINK(link.dev), .CLOCK(clock), .SYS_RST(sys_rst),
        .RESULT_A0(res_a0), .RESULT_A1(res_a1), .RESULT_B0(res_b0), .RESULT_B1(res_b1),
        .HOLD(hold), .CUR_PAIR(cur_pair));
    dsro_host #(.HALF_CYC(SCLK_HALF_CYC), .DEPTH(FIFO_DEPTH)) dsro_host_inst (
        .LINK(link.host), .CLOCK(clock), .SYS_RST(sys_rst), .RUN(run),
        .CHCOUNT_SEL(chcount), .OUTPORT_SEL(outport), .PAIR_SEL(pair_sel),
        .OUT_DATA(out_data), .OUT_VALID(out_valid), .OUT_READY(out_ready));
    dsro_link_checker dsro_link_checker_inst (.CLOCK(clock), .SYS_RST(sys_rst),
        .conv_trig(link.conv_trig), .read_strobe(link.read_strobe), .cs_n(link.cs_n),
        .chcount_sel(link.chcount_sel), .outport_sel(link.outport_sel), .sclk(link.sclk),
        .busy(link.busy), .sdo_a_o(link.sdo_a_o), .sdo_a_oe(link.sdo_a_oe),
        .sdo_b_oe(link.sdo_b_oe));
    // ========================================================
    // Collect popped words
    always @(posedge clock) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            words.push_back(out_data);
        end
    end
    // Watch the wire for whole frames
    always @(negedge link.sclk) begin
        if (link.cs_n === 1'b0) begin
            sh = {sh[14:0], sdo_a};
            seen_a = seen_a | (sh === want_a);
            seen_b = seen_b | (sh === want_b);
            b_drv = b_drv | (link.sdo_b_oe === 1'b1);
        end
    end
    // Hold must follow the trigger at once
    always @(posedge link.conv_trig) begin
        #1;
        chk_bit(hold, 1'b1);
    end
    // ========================================================
    // Expected frame, compares and waits
    function automatic dsro_frame_t exp_frame(input logic pr, input logic ch);
        dsro_result_t r;
        r = pr ? (ch ? res_b1 : res_a1) : (ch ? res_b0 : res_a0);
        return {pr, ch, r, 2'b00};
    endfunction : exp_frame
    task automatic chk_frame(input dsro_frame_t got, input dsro_frame_t exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_frame
    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit
    task automatic print_verdict();
        $display("Checks %0d, miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    // Bounded wait: n words, or n quiet cycles when idle is set
    task automatic wait_for(input int n, input logic idle);
        int k;
        int q;
        q = 0;
        for (k = 0; k < 30000 && (idle ? q < n : words.size() < n); k++) begin
            @(negedge clock);
            q = (link.busy === 1'b0 && link.cs_n === 1'b1
                && (out_valid === 1'b0 || out_ready === 1'b0)) ? q + 1 : 0;
        end
        if (k == 30000) begin
            chk_bit(1'b0, 1'b1);
            print_verdict();
        end
    endtask : wait_for
    // One mode: run, collect n words, stop, check frames and wire
    task automatic run_phase(input logic ch, input logic op, input logic ps, input int n);
        int i;
        logic pr;
        chcount = ch;
        outport = op;
        pair_sel = ps;
        want_a = exp_frame(ch | ps, CHAN_A);
        want_b = exp_frame(ch | ps, CHAN_B);
        seen_a = 1'b0;
        seen_b = 1'b0;
        words.delete();
        run = 1'b1;
        wait_for(2, 1'b0);
        b_drv = 1'b0;
        wait_for(n, 1'b0);
        run = 1'b0;
        wait_for(60, 1'b1);
        for (i = 2; i + 1 < words.size(); i += 2) begin
            pr = ch ? ~words[i - 2][15] : ps;
            chk_frame(words[i], exp_frame(pr, CHAN_A));
            chk_frame(words[i + 1], exp_frame(pr, CHAN_B));
        end
        chk_bit(seen_a, 1'b1);
        chk_bit(b_drv, ~op);
        chk_bit(cur_pair, words[words.size() - 1][15]);
        if (op) begin
            chk_bit(seen_b, 1'b1);
        end
    endtask : run_phase
    // ========================================================
    // Main sequence
    initial begin
        repeat (4) @(negedge clock);
        sys_rst = 1'b0;
        run_phase(1'b0, 1'b0, 1'b1, 8);
        chk_frame(words[0], exp_frame(1'b0, CHAN_A));
        res_a0 = 12'h123;
        res_b0 = 12'hEDC;
        run_phase(1'b0, 1'b0, 1'b0, 8);
        run_phase(1'b1, 1'b0, 1'b0, 8);
        run_phase(1'b0, 1'b1, 1'b1, 8);
        run_phase(1'b1, 1'b1, 1'b0, 8);
        // Fill the buffer with reads stalled, then drain it
        out_ready = 1'b0;
        outport = 1'b0;
        words.delete();
        run = 1'b1;
        // Long enough for 17 conversions, so the host stalls on a full buffer
        repeat (8000) @(negedge clock);
        run = 1'b0;
        out_ready = 1'b1;
        wait_for(60, 1'b1);
        chk_bit(words.size() inside {[FIFO_DEPTH:FIFO_DEPTH + 2]}, 1'b1);
        chk_bit(out_valid, 1'b0);
        print_verdict();
    end
endmodule : dsro_tb
